// File: hw/dd_digit_ram.sv
// digit store: one byte per digit, one write port, registered read port
`timescale 1ns/1ps
module dd_digit_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata_r
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // the array itself carries no reset so it maps onto plain storage
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data leave through a register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= mem[raddr];
        end
    end

endmodule

// File: hw/dd_pkg.sv
// package: frame layout, register addresses, reset values and scan timing
package dd_pkg;

    // ------------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------------
    localparam int FRAME_W = 16;

    // one frame as it sits in the shift register, first bit received at the top
    typedef struct packed {
        logic [3:0] ignored;
        logic [3:0] addr;
        logic [7:0] data;
    } dd_frame_t;

    // ------------------------------------------------------------------
    // register addresses carried in the frame
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_NOOP = 4'h0;
    localparam logic [3:0] ADDR_DIGIT_FIRST = 4'h1;
    localparam logic [3:0] ADDR_DIGIT_LAST = 4'h8;
    localparam logic [3:0] ADDR_DECODE = 4'h9;
    localparam logic [3:0] ADDR_INTENSITY = 4'ha;
    localparam logic [3:0] ADDR_SCAN_LIMIT = 4'hb;
    localparam logic [3:0] ADDR_SHUTDOWN = 4'hc;
    localparam logic [3:0] ADDR_DISPLAY_TEST = 4'hf;

    // ------------------------------------------------------------------
    // values after reset: shut down, one digit, no decode, dimmest
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DECODE = 8'h00;
    localparam logic [3:0] RST_INTENSITY = 4'h0;
    localparam logic [2:0] RST_SCAN_LIMIT = 3'h0;
    localparam logic RST_SHUTDOWN = 1'b1;
    localparam logic RST_TEST = 1'b0;

    // ------------------------------------------------------------------
    // scan timing: 800 Hz over eight digits at a 50 ns clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int DIGIT_SLOT_NS = 156250;
    localparam int DIGIT_SLOT_CYC = DIGIT_SLOT_NS / CLK_PERIOD_NS;
    localparam int INTENSITY_STEPS = 16;
    localparam logic [11:0] SLOT_LAST = 12'(DIGIT_SLOT_CYC - 1);
    localparam logic [11:0] SLOT_STEP = 12'(DIGIT_SLOT_CYC / INTENSITY_STEPS);
    localparam logic [11:0] SLOT_GUARD = 12'h002;
    localparam logic [2:0] SCAN_ALL = 3'h7;

    // ------------------------------------------------------------------
    // pin carriers: value and output enable per line
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } dd_drive8_t;

    typedef struct packed {
        logic [6:0] o;
        logic [6:0] oe;
    } dd_drive7_t;

    typedef struct packed {
        logic o;
        logic oe;
    } dd_drive1_t;

    // code-b font, segments a..g with a in the top bit
    function automatic logic [6:0] dd_font(input logic [3:0] code);
        logic [6:0] seg;
        seg = 7'h00;
        case (code)
            4'h0: seg = 7'h7e;
            4'h1: seg = 7'h30;
            4'h2: seg = 7'h6d;
            4'h3: seg = 7'h79;
            4'h4: seg = 7'h33;
            4'h5: seg = 7'h5b;
            4'h6: seg = 7'h5f;
            4'h7: seg = 7'h70;
            4'h8: seg = 7'h7f;
            4'h9: seg = 7'h7b;
            4'ha: seg = 7'h01;
            4'hb: seg = 7'h4f;
            4'hc: seg = 7'h37;
            4'hd: seg = 7'h0e;
            4'he: seg = 7'h67;
            default: seg = 7'h00;
        endcase
        return seg;
    endfunction

endpackage

// File: hw/dd_serial_display.sv
// serial load port, frame execution and digit scan of the display driver
//
// Contract
// [R1] shift serial input on each rising serial clock
// [R2] load rising edge latches last sixteen bits
// [R3] select low while shifting; rising select latches
// [R4] select high: serial clock edges are ignored
// [R5] serial output changes on falling clock edge
// [R6] input reappears at output sixteen-and-half cycles later
// [R7] serial output always driven, never floating
// [R8] frame: four ignored, four address, eight data
// [R9] digit lines sink; off pulled up or floating
// [R10] segment off pulled low or left floating
// [R11] seven segments plus point source when on
// [R12] host sends bit fifteen first
// [R13] host raises latch after sixteenth edge only
// [R14] latched byte written to addressed register
`timescale 1ns/1ps
module dd_serial_display #(
    parameter bit CS_VARIANT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic serial_din,
    input wire logic load_or_cs_n,
    output logic serial_dout,
    output dd_pkg::dd_drive8_t digit_drive_lines,
    output dd_pkg::dd_drive7_t segment_drive_lines,
    output dd_pkg::dd_drive1_t decimal_point_drive
);

    // ------------------------------------------------------------------
    // link side: shift register on the serial clock
    // ------------------------------------------------------------------
    logic [15:0] sh_r;
    logic [14:0] sh_low;
    logic shift_en;
    logic dout_r;
    dd_pkg::dd_frame_t frame_r;
    logic frame_tog_r;

    // load variant shifts whatever the latch pin does; select variant only while low
    assign shift_en = !CS_VARIANT || !load_or_cs_n; // R4
    assign sh_low = sh_r[14:0];

    // first bit received ends up in the top bit, so the frame lands msb first
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            sh_r <= '0;
        end else if (shift_en) begin
            sh_r <= {sh_low, serial_din}; // R1 R3 R12
        end
    end

    // the leaving bit goes out half a cycle after it reaches the last stage
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            dout_r <= 1'b0;
        end else if (shift_en) begin
            dout_r <= sh_r[15]; // R5 R6
        end
    end

    // plain push-pull pin, no enable exists for it
    assign serial_dout = dout_r; // R7

    // the latch pin's rising edge clocks the frame out of the shifter; the
    // host keeps the serial clock still around it, so sh_r is quiet here
    always_ff @(posedge load_or_cs_n or negedge rst_n) begin
        if (!rst_n) begin
            frame_r <= '0;
            frame_tog_r <= 1'b0;
        end else begin
            frame_r <= dd_pkg::dd_frame_t'(sh_r); // R2 R3 R13
            frame_tog_r <= ~frame_tog_r;
        end
    end

    // ------------------------------------------------------------------
    // crossing: toggle through two flops, frame word held stable meanwhile
    // ------------------------------------------------------------------
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic tog_seen;
    logic exec_stb_r;
    dd_pkg::dd_frame_t frm_r;

    assign tog_seen = tog_s2_r != tog_s3_r;

    // frame_r cannot move again for sixteen serial clocks, far longer than the sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
            exec_stb_r <= 1'b0;
            frm_r <= '0;
        end else begin
            tog_s1_r <= frame_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
            exec_stb_r <= tog_seen; // R2
            if (tog_seen) begin
                frm_r <= frame_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------------
    logic is_digit;
    logic wr_decode;
    logic wr_intensity;
    logic wr_scan;
    logic wr_shutdown;
    logic wr_test;
    logic ram_we;
    logic [2:0] ram_waddr;
    logic frm_d0;

    // the top nibble of the frame is never looked at
    assign is_digit = frm_r.addr >= dd_pkg::ADDR_DIGIT_FIRST
        && frm_r.addr <= dd_pkg::ADDR_DIGIT_LAST; // R8
    assign wr_decode = exec_stb_r && frm_r.addr == dd_pkg::ADDR_DECODE;
    assign wr_intensity = exec_stb_r && frm_r.addr == dd_pkg::ADDR_INTENSITY;
    assign wr_scan = exec_stb_r && frm_r.addr == dd_pkg::ADDR_SCAN_LIMIT;
    assign wr_shutdown = exec_stb_r && frm_r.addr == dd_pkg::ADDR_SHUTDOWN;
    assign wr_test = exec_stb_r && frm_r.addr == dd_pkg::ADDR_DISPLAY_TEST;
    assign ram_we = exec_stb_r && is_digit; // R14
    assign ram_waddr = 3'(frm_r.addr - dd_pkg::ADDR_DIGIT_FIRST);
    assign frm_d0 = frm_r.data[0];

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [7:0] decode_r;
    logic [3:0] intensity_r;
    logic [2:0] scan_lim_r;
    logic shutdown_r;
    logic test_r;

    // no-op and unused addresses fall through and change nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            decode_r <= dd_pkg::RST_DECODE;
            intensity_r <= dd_pkg::RST_INTENSITY;
            scan_lim_r <= dd_pkg::RST_SCAN_LIMIT;
            shutdown_r <= dd_pkg::RST_SHUTDOWN;
            test_r <= dd_pkg::RST_TEST;
        end else begin
            if (wr_decode) decode_r <= frm_r.data; // R14
            if (wr_intensity) intensity_r <= frm_r.data[3:0];
            if (wr_scan) scan_lim_r <= frm_r.data[2:0];
            if (wr_shutdown) shutdown_r <= !frm_d0; // R14
            if (wr_test) test_r <= frm_d0;
        end
    end

    // ------------------------------------------------------------------
    // scan: slot counter and digit index
    // ------------------------------------------------------------------
    logic blank;
    logic [11:0] slot_cnt_r;
    logic [11:0] slot_cnt_nxt;
    logic [2:0] dig_idx_r;
    logic [2:0] dig_idx_nxt;
    logic [2:0] scan_top;
    logic [2:0] rd_idx_r;
    logic slot_end;

    // display test overrides shutdown and lights every digit
    assign blank = shutdown_r && !test_r;
    assign scan_top = test_r ? dd_pkg::SCAN_ALL : scan_lim_r;
    assign slot_end = slot_cnt_r == dd_pkg::SLOT_LAST;
    assign slot_cnt_nxt = slot_end ? 12'h000 : 12'(slot_cnt_r + 12'h001);
    assign dig_idx_nxt = !slot_end ? dig_idx_r
        : (dig_idx_r >= scan_top) ? 3'h0 : 3'(dig_idx_r + 3'h1);

    // scanning stops in shutdown unless display test is on, as a halted oscillator would
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_cnt_r <= 12'h000;
            dig_idx_r <= 3'h0;
            rd_idx_r <= 3'h0;
        end else if (!blank) begin
            slot_cnt_r <= slot_cnt_nxt;
            dig_idx_r <= dig_idx_nxt;
            rd_idx_r <= dig_idx_r;
        end
    end

    // ------------------------------------------------------------------
    // digit store
    // ------------------------------------------------------------------
    logic [7:0] ram_rdata;

    dd_digit_ram #(
        .WIDTH(8),
        .DEPTH(8),
        .AW(3)
    ) u_ram (
        .clk(clk),
        .rst_n(rst_n),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(frm_r.data),
        .raddr(dig_idx_r),
        .rdata_r(ram_rdata)
    );

    // ------------------------------------------------------------------
    // segment pattern and brightness window
    // ------------------------------------------------------------------
    logic [11:0] on_len;
    logic lit;
    logic [6:0] seg_pat;
    logic dp_pat;
    logic [6:0] seg_on;
    logic dp_on;

    // the first cycles of a slot stay dark while the read data catch up, so
    // the previous digit's pattern never ghosts onto the new digit
    assign on_len = 12'((12'(intensity_r) + 12'h001) * dd_pkg::SLOT_STEP);
    assign lit = !blank && slot_cnt_r >= dd_pkg::SLOT_GUARD
        && (test_r || slot_cnt_r < on_len);
    assign seg_pat = decode_r[rd_idx_r] ? dd_pkg::dd_font(ram_rdata[3:0])
        : ram_rdata[6:0];
    assign dp_pat = ram_rdata[7];
    assign seg_on = !lit ? 7'h00 : test_r ? 7'h7f : seg_pat; // R11
    assign dp_on = lit && (test_r || dp_pat); // R11

    // ------------------------------------------------------------------
    // pin drive, one generate entry per digit line
    // ------------------------------------------------------------------
    logic [7:0] dig_on;
    logic [7:0] dig_o_nxt;
    logic [7:0] dig_oe_nxt;

    for (genvar g = 0; g < 8; g++) begin : g_dig
        assign dig_on[g] = lit && rd_idx_r == 3'(g);
        // an active digit sinks; an idle one is pulled up or let float
        assign dig_o_nxt[g] = !dig_on[g]; // R9
        assign dig_oe_nxt[g] = dig_on[g] || !CS_VARIANT; // R9
    end

    // every pin value and enable leaves through a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            digit_drive_lines <= '{o: 8'hff, oe: CS_VARIANT ? 8'h00 : 8'hff};
            segment_drive_lines <= '{o: 7'h00, oe: CS_VARIANT ? 7'h00 : 7'h7f};
            decimal_point_drive <= '{o: 1'b0, oe: !CS_VARIANT};
        end else begin
            digit_drive_lines <= '{o: dig_o_nxt, oe: dig_oe_nxt};
            // off segments are pulled to ground or let float
            segment_drive_lines <= '{o: seg_on, oe: seg_on | {7{!CS_VARIANT}}}; // R10
            decimal_point_drive <= '{o: dp_on, oe: dp_on || !CS_VARIANT}; // R10
        end
    end

    // ------------------------------------------------------------------
    // checks on the link side
    // ------------------------------------------------------------------
    a_shift_in: assert property (@(posedge sclk) disable iff (!rst_n) // R1
        shift_en |=> sh_r == {$past(sh_low), $past(serial_din)})
        else $error("shift register did not take the input bit");

    a_shift_hold: assert property (@(posedge sclk) disable iff (!rst_n) // R4
        !shift_en |=> $stable(sh_r))
        else $error("shift register moved while deselected");

    a_dout_leave: assert property (@(posedge sclk) disable iff (!rst_n) // R5
        shift_en && $past(shift_en) |-> dout_r == sh_r[15])
        else $error("serial output is not the leaving bit");

    // ------------------------------------------------------------------
    // checks on the system side
    // ------------------------------------------------------------------
    a_frame_exec: assert property (@(posedge clk) disable iff (!rst_n) // R2
        tog_seen |=> exec_stb_r && frm_r == $past(frame_r))
        else $error("latched frame was not taken over");

    a_shutdown_wr: assert property (@(posedge clk) disable iff (!rst_n) // R14
        wr_shutdown |=> shutdown_r == !$past(frm_d0))
        else $error("shutdown register not written");

    a_intensity_wr: assert property (@(posedge clk) disable iff (!rst_n) // R14
        wr_intensity |=> ##1 intensity_r == $past(frm_r.data[3:0], 2))
        else $error("intensity register not written");

    a_digit_off: assert property (@(posedge clk) disable iff (!rst_n) // R9
        blank |=> digit_drive_lines.o == 8'hff
            && digit_drive_lines.oe == (CS_VARIANT ? 8'h00 : 8'hff))
        else $error("digit lines not released while blanked");

    a_seg_off: assert property (@(posedge clk) disable iff (!rst_n) // R10
        blank |=> segment_drive_lines.o == 7'h00
            && segment_drive_lines.oe == (CS_VARIANT ? 7'h00 : 7'h7f)
            && !decimal_point_drive.o)
        else $error("segment lines not released while blanked");

    a_test_all_on: assert property (@(posedge clk) disable iff (!rst_n) // R11
        test_r && lit |=> segment_drive_lines.o == 7'h7f
            && decimal_point_drive.o && segment_drive_lines.oe == 7'h7f)
        else $error("display test did not light all segments");

    c_digit_write: cover property (@(posedge clk) disable iff (!rst_n) ram_we);
    c_leave_shutdown: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(shutdown_r));
    c_test_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(test_r));
    c_deselect: cover property (@(posedge sclk) disable iff (!rst_n) !shift_en);

endmodule

// File: tb/dd_host_model.sv
// host model: drives the three-wire link and samples both serial outputs
`timescale 1ns/1ps
module dd_host_model (
    output logic sclk,
    output logic serial_din,
    output logic load,
    output logic cs_n,
    input wire logic dout_load,
    input wire logic dout_cs,
    output logic [15:0] seen_load,
    output logic [15:0] seen_cs,
    output int bad_edges
);
    // ----------------------------------------------------------------
    // idle levels: clock parked low, select high, latch low
    // ----------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        serial_din = 1'b0;
        load = 1'b0;
        cs_n = 1'b1;
        seen_load = 16'h0000;
        seen_cs = 16'h0000;
        bad_edges = 0;
    end

    // shift n bits at 64 ns per bit, optionally with select and a latch at the end
    task automatic shift(input logic [15:0] bits, input int n, input bit sel, input bit latch);
        logic a;
        logic b;
        if (sel) cs_n = 1'b0;
        #32;
        for (int i = n - 1; i >= 0; i--) begin
            serial_din = bits[i];
            #31;
            seen_load = {seen_load[14:0], dout_load};
            seen_cs = {seen_cs[14:0], dout_cs};
            a = dout_load;
            b = dout_cs;
            #1 sclk = 1'b1;
            #2;
            // outputs must not move on the rising edge
            if (dout_load !== a || dout_cs !== b) bad_edges++;
            #30 sclk = 1'b0;
        end
        // a released data line must not look like it still holds the last bit
        serial_din = ~serial_din;
        #32;
        if (latch) begin
            load = 1'b1;
            cs_n = 1'b1;
            #64 load = 1'b0;
            #400;
        end else begin
            #64;
        end
    endtask
endmodule

// File: tb/tb_top.sv
// top-level bench: load and select variants side by side on one host link
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [7:0] dec;
        logic [7:0] data;
        logic [6:0] segs;
        logic pt;
    } dd_row_t;

    // no-decode and decode rows; data bits 6..4 ignored in decode mode, bit 7 still drives the point
    localparam dd_row_t ROWS [5] = '{
        '{8'h00, 8'ha5, 7'h25, 1'b1},
        '{8'h00, 8'h7f, 7'h7f, 1'b0},
        '{8'h01, 8'h03, 7'h79, 1'b0},
        '{8'h01, 8'hfc, 7'h37, 1'b1},
        '{8'hff, 8'h0b, 7'h4f, 1'b0}
    };
    localparam logic [15:0] SETUP [5] = '{16'h0c01, 16'h0b00, 16'h5a0f, 16'h0f00, 16'h0000};

    logic clk;
    logic rst_n;
    logic sclk;
    logic serial_din;
    logic load;
    logic cs_n;
    logic dout_l;
    logic dout_c;
    logic [15:0] seen_l;
    logic [15:0] seen_c;
    int bad_edges;
    int num_errors;
    int samples_checked;
    dd_pkg::dd_drive8_t digit_l;
    dd_pkg::dd_drive8_t digit_c;
    dd_pkg::dd_drive7_t segment_l;
    dd_pkg::dd_drive7_t segment_c;
    dd_pkg::dd_drive1_t point_l;
    dd_pkg::dd_drive1_t point_c;

    // ----------------------------------------------------------------
    // instances
    // ----------------------------------------------------------------
    dd_serial_display #(.CS_VARIANT(1'b0)) u_dd_serial_display (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .serial_din(serial_din),
        .load_or_cs_n(load), .serial_dout(dout_l), .digit_drive_lines(digit_l),
        .segment_drive_lines(segment_l), .decimal_point_drive(point_l)
    );
    dd_serial_display #(.CS_VARIANT(1'b1)) u_dd_serial_display_cs (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .serial_din(serial_din),
        .load_or_cs_n(cs_n), .serial_dout(dout_c), .digit_drive_lines(digit_c),
        .segment_drive_lines(segment_c), .decimal_point_drive(point_c)
    );
    dd_host_model u_dd_host_model (
        .sclk(sclk), .serial_din(serial_din), .load(load), .cs_n(cs_n),
        .dout_load(dout_l), .dout_cs(dout_c), .seen_load(seen_l), .seen_cs(seen_c),
        .bad_edges(bad_edges)
    );

    // system clock, 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // bounded wait until the given digit pattern is driven with some segment lit
    task automatic wait_lit(input logic [7:0] dig, input int limit);
        int n;
        n = 0;
        while (!(digit_l.o === dig && segment_l.o !== 7'h00) && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (n >= limit) begin
            num_errors++;
            $display("[ERR] %0t waited %h limit %h", $time, n, limit);
            end_of_test();
        end
    endtask

    // blank display: load part pulls lines to off levels, select part floats them
    task automatic check_blank();
        check({point_l.o, segment_l.o, digit_l.o}, 16'h00ff);
        check({point_l.oe, segment_l.oe, digit_l.oe}, 16'hffff);
        check({point_c.oe, segment_c.oe, digit_c.oe}, 16'h0000);
    endtask

    // a hang anywhere counts as a failure
    initial begin
        #4ms;
        num_errors++;
        $display("[ERR] %0t watchdog %h limit %h", $time, 1, 0);
        end_of_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        num_errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        check_blank();
        check({14'h0000, dout_l, dout_c}, 16'h0000);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check_blank();
        foreach (SETUP[i]) u_dd_host_model.shift(SETUP[i], 16, 1'b1, 1'b1);
        // table rows: decode mode then digit 0 byte, ignored nibble nonzero
        for (int i = 0; i < 5; i++) begin
            u_dd_host_model.shift({8'h39, ROWS[i].dec}, 16, 1'b1, 1'b1);
            u_dd_host_model.shift({8'hc1, ROWS[i].data}, 16, 1'b1, 1'b1);
            repeat (3200) @(negedge clk);
            wait_lit(8'hfe, 4000);
            check({point_l.o, segment_l.o, digit_l.o}, {ROWS[i].pt, ROWS[i].segs, 8'hfe});
            check({point_l.oe, segment_l.oe, digit_l.oe}, 16'hffff);
            check({point_c.oe, segment_c.oe, digit_c.oe},
                {ROWS[i].pt, ROWS[i].segs, 8'h01});
        end
        // daisy chain: one frame comes back out during the next
        u_dd_host_model.shift(16'h40c3, 16, 1'b1, 1'b1);
        u_dd_host_model.shift(16'h7096, 16, 1'b1, 1'b1);
        check(seen_l, 16'h40c3);
        check(seen_c, 16'h40c3);
        // stray clocks with select high reach only the load part
        u_dd_host_model.shift(16'h00b4, 8, 1'b0, 1'b0);
        u_dd_host_model.shift(16'h0000, 16, 1'b1, 1'b1);
        check(seen_c, 16'h7096);
        check(seen_l, 16'h96b4);
        check(bad_edges[15:0], 16'h0000);
        check({14'h0000, dout_l, dout_c}, 16'h0000);
        // shutdown frame blanks both parts
        u_dd_host_model.shift(16'h0c00, 16, 1'b1, 1'b1);
        repeat (8) @(negedge clk);
        check_blank();
        // display test overrides shutdown: every segment lit on every scanned digit
        u_dd_host_model.shift(16'h0f01, 16, 1'b1, 1'b1);
        wait_lit(8'hfe, 4000);
        check({point_l.o, segment_l.o, digit_l.o}, 16'hfffe);
        check({point_c.oe, segment_c.oe, digit_c.oe}, 16'hff01);
        // the next slot moves the scan on to digit 1
        wait_lit(8'hfd, 4000);
        check({point_l.o, segment_l.o, digit_l.o}, 16'hfffd);
        check({point_c.oe, segment_c.oe, digit_c.oe}, 16'hff02);
        // test off while still shut down blanks again
        u_dd_host_model.shift(16'h0f00, 16, 1'b1, 1'b1);
        repeat (8) @(negedge clk);
        check_blank();
        // back to normal, then a reset in mid-run must blank again
        u_dd_host_model.shift(16'h0c01, 16, 1'b1, 1'b1);
        repeat (3200) @(negedge clk);
        wait_lit(8'hfe, 4000);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check_blank();
        check({14'h0000, dout_l, dout_c}, 16'h0000);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3200) @(negedge clk);
        check_blank();
        end_of_test();
    end
endmodule
